// ### pmcu_host_model.sv
`timescale 1ns/1ps
module pmcu_host_model (
  input  wire logic        ref_clk,
  output logic             cmd_valid,
  output logic [1:0]       cmd_kind,
  output logic [7:0]       cmd_code,
  output logic [6:0]       cmd_addr,
  output logic             cmd_page,
  output logic [31:0]      cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_err,
  input  wire logic [31:0] rsp_data,
  input  wire logic [15:0] rsp_aux
);
  initial begin
    cmd_valid = 1'b0;
    cmd_kind  = 2'h0;
    cmd_code  = 8'h00;
    cmd_addr  = 7'h00;
    cmd_page  = 1'b0;
    cmd_wdata = 32'h0;
  end
  // Inverted released fields cannot pass for live ones.
  task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [6:0] a,
                      input logic p, input logic [31:0] w, output logic got,
                      output logic err, output logic [31:0] d, output logic [15:0] x);
    @(negedge ref_clk);
    cmd_kind  = k;
    cmd_code  = c;
    cmd_addr  = a;
    cmd_page  = p;
    cmd_wdata = w;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    got = rsp_valid;
    err = rsp_err;
    d   = rsp_data;
    x   = rsp_aux;
    cmd_valid = 1'b0;
    cmd_code  = ~c;
    cmd_wdata = ~w;
  endtask : xfer
endmodule : pmcu_host_model

// ### pmcu_pkg.sv
// Summary of operation
// - Enable stays low at least the per-channel restart hold time, default 0x4900, unless a commanded restart or reset cuts the hold short.
// - Per channel, keep the highest output voltage sample since the last peak clear.
// - Keep the highest input voltage sample since the last peak clear.
// - Keep the highest die temperature since the last peak clear, one copy only.
// - Peak clear send-byte restarts capture of every peak, here and downstream.
// - A channel re-enables only after output decays below the discharge level.
// - Answer on the seven-bit bus address setting, default 0x4F.
// - Upper timestamp goes first; writing it clears the lower 32 bits.
// - Fault record force writes a log entry at once, fault or not.
// - Fault record erase wipes all entries, harmless when already empty.
// - Reading the fault record code returns the stored log contents.
// - Compare send-byte checks all working values against nonvolatile memory; here it only pulses nvm_compare_command.
// - Power good rises after output stays in window for the assert delay.
// - Power good falls after output stays out of window for the deassert delay.
// - A byte setting, default 0x00, picks sync pin direction.
// - Also accept commands on the per-channel shared rail address, default 0x80.
// - Any nonzero written output kill value keeps outputs off until reset.
// - Active user write protect rejects writes to nonvolatile-backed settings.
// - Commanded restart send-byte performs a full reset without power removal.
// - Linear eleven: signed mantissa bits 10..0 times two to signed bits 15..11.
// - Unsigned fixed: bits 15..0 unsigned times two to minus twelve.
// - Half precision: sign 15, biased exponent 14..10 bias 15, fraction 9..0.
package pmcu_pkg;
  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned MS_PER_S   = 1000;
  localparam int unsigned MS_CYC     = CLK_HZ / MS_PER_S;
  localparam logic [14:0] MS_CYC_M1  = 15'(MS_CYC - 1);
  localparam int          L11_SHIFT  = 16;
  localparam int          UNSIGNED_FIXED_FORMAT_FRAC  = 12;
  localparam int          HP_SIGN    = 15;
  localparam int          HP_EXP_LSB = 10;
  localparam int          HP_BIAS    = 15;
  localparam int          RAIL_OFF   = 7;
  localparam int          SYNC_DIR   = 0;
  localparam logic [7:0] C_RESTART = 8'hDC;
  localparam logic [7:0] C_VOPK    = 8'hDD;
  localparam logic [7:0] C_VIPK    = 8'hDE;
  localparam logic [7:0] C_TPK     = 8'hDF;
  localparam logic [7:0] C_CLRPK   = 8'hE3;
  localparam logic [7:0] C_DISCH   = 8'hE4;
  localparam logic [7:0] C_PADS    = 8'hE5;
  localparam logic [7:0] C_ADDR    = 8'hE6;
  localparam logic [7:0] C_SPID    = 8'hE7;
  localparam logic [7:0] C_TSHI    = 8'hE8;
  localparam logic [7:0] C_TSLO    = 8'hE9;
  localparam logic [7:0] C_FLST    = 8'hEA;
  localparam logic [7:0] C_FLCLR   = 8'hEC;
  localparam logic [7:0] C_FLRD    = 8'hEE;
  localparam logic [7:0] C_COMMON  = 8'hEF;
  localparam logic [7:0] C_NVCMP   = 8'hF0;
  localparam logic [7:0] C_CHST    = 8'hF1;
  localparam logic [7:0] C_PGD     = 8'hF2;
  localparam logic [7:0] C_NPGD    = 8'hF3;
  localparam logic [7:0] C_PHASE   = 8'hF5;
  localparam logic [7:0] C_SYNC    = 8'hF6;
  localparam logic [7:0] C_STRAP   = 8'hF7;
  localparam logic [7:0] C_RAIL    = 8'hFA;
  localparam logic [7:0] C_KILL    = 8'hFB;
  localparam logic [7:0] C_WP      = 8'hFC;
  localparam logic [7:0] C_RESET   = 8'hFD;
  localparam logic [15:0] D_RESTART = 16'h4900;
  localparam logic [15:0] D_DISCH   = 16'h3266;
  localparam logic [15:0] D_PGD     = 16'h3C00;
  localparam logic [15:0] D_NPGD    = 16'h2E66;
  localparam logic [15:0] D_PH0     = 16'h0000;
  localparam logic [15:0] D_PH1     = 16'h59A0;
  localparam logic [6:0]  D_ADDR    = 7'h4F;
  localparam logic [7:0]  D_RAIL    = 8'h80;
  localparam logic [7:0]  D_BYTE0   = 8'h00;

  typedef enum logic [1:0] {
    PMCU_K_WRITE = 2'b00,
    PMCU_K_READ  = 2'b01,
    PMCU_K_SEND  = 2'b10
  } pmcu_kind_t;

  typedef enum logic [1:0] {
    PMCU_CH_OFF   = 2'b00,
    PMCU_CH_DISCH = 2'b01,
    PMCU_CH_ON    = 2'b10,
    PMCU_CH_HOLD  = 2'b11
  } pmcu_chan_t;
endpackage : pmcu_pkg

// ### pmcu_regs.sv
`timescale 1ns/1ps
module pmcu_regs #(
  parameter logic [15:0] SPECIAL_ID = 16'hA5A5 // Arbitrary value.
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [6:0]  cmd_addr,
  input  wire logic        cmd_page,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        meas_valid,
  input  wire logic [15:0] vout_meas0,
  input  wire logic [15:0] vout_meas1,
  input  wire logic [15:0] vin_meas,
  input  wire logic [15:0] temp_meas,
  input  wire logic [1:0]  run_pin,
  input  wire logic [1:0]  vout_in_window,
  output logic [1:0]       chan_enable,
  output logic [1:0]       power_good_output,
  output logic             sync_pin_is_output,
  output logic             rsp_valid,
  output logic             rsp_ack,
  output logic             rsp_err,
  output logic [31:0]      rsp_data,
  output logic [15:0]      rsp_aux,
  output logic             peak_clear_command,
  output logic             fault_record_force,
  output logic             fault_record_erase,
  output logic             nvm_compare_command,
  output logic             commanded_restart
);
  typedef struct packed {
    logic [1:0][15:0]       restart;
    logic [1:0][15:0]       disch;
    logic [1:0][15:0]       pgd;
    logic [1:0][15:0]       npgd;
    logic [1:0][15:0]       phase;
    logic [1:0][7:0]        rail;
    logic [6:0]             addr;
    logic [7:0]             sync;
    logic [7:0]             kill;
    logic [7:0]             wp;
    logic [1:0][15:0]       pk_vo;
    logic [15:0]            pk_vi;
    logic [15:0]            pk_t;
    logic [3:0]             pk_ok;
    logic [14:0]            ms_cnt;
    logic [12:0]            ts_hi;
    logic [31:0]            ts_lo;
    logic [31:0]            ts_snap;
    logic                   fl_ok;
    logic [12:0]            fl_hi;
    logic [31:0]            fl_lo;
    pmcu_pkg::pmcu_chan_t [1:0] cst;
    logic [1:0][31:0]       tmr;
    logic [1:0][31:0]       pgcnt;
    logic [1:0]             pg;
    logic [1:0]             en;
    logic [1:0]             run_m;
    logic [1:0]             run_s;
    logic [1:0]             win_m;
    logic [1:0]             win_s;
    logic                   r_valid;
    logic                   r_ack;
    logic                   r_err;
    logic [31:0]            r_data;
    logic [15:0]            r_aux;
    logic [4:0]             pulse;
  } pmcu_state_t;

  function automatic pmcu_state_t init_state();
    pmcu_state_t t;
    t = '0;
    for (int c = 0; c < 2; c++) begin
      t.restart[c] = pmcu_pkg::D_RESTART;
      t.disch[c]   = pmcu_pkg::D_DISCH;
      t.pgd[c]     = pmcu_pkg::D_PGD;
      t.npgd[c]    = pmcu_pkg::D_NPGD;
      t.rail[c]    = pmcu_pkg::D_RAIL;
      t.cst[c]     = pmcu_pkg::PMCU_CH_OFF;
    end
    t.phase[0] = pmcu_pkg::D_PH0;
    t.phase[1] = pmcu_pkg::D_PH1;
    t.addr     = pmcu_pkg::D_ADDR;
    t.sync     = pmcu_pkg::D_BYTE0;
    t.kill     = pmcu_pkg::D_BYTE0;
    t.wp       = pmcu_pkg::D_BYTE0;
    return t;
  endfunction : init_state

  localparam pmcu_state_t RST = init_state();

  // Linear eleven value scaled by two to the sh, as a wide signed integer.
  function automatic logic signed [63:0] l11_fix(input logic [15:0] raw, input int sh);
    logic signed [63:0] y;
    int                 e;
    y = 64'(signed'(raw[10:0]));
    e = int'(signed'(raw[15:11])) + sh;
    return (e >= 0) ? (y <<< e) : (y >>> (-e));
  endfunction : l11_fix

  // Half precision setting times mul, rounded up so a hold is never short.
  function automatic logic [31:0] hp_scale(input logic [15:0] raw, input logic [31:0] mul);
    logic [63:0] p;
    int          e;
    p = 64'({raw[14:10] != 5'h00, raw[9:0]}) * 64'(mul);
    e = int'((raw[14:10] == 5'h00) ? 5'h01 : raw[14:10]);
    e = e - pmcu_pkg::HP_BIAS - pmcu_pkg::HP_EXP_LSB;
    if (e >= 0) begin
      p = p << e;
    end else begin
      p = (p + (64'h1 << (-e)) - 64'h1) >> (-e);
    end
    if (raw[pmcu_pkg::HP_SIGN] || p == 64'h0) begin
      return 32'h1;
    end
    if (p > 64'h0000_0000_FFFF_FFFF) begin
      return 32'hFFFF_FFFF;
    end
    return p[31:0];
  endfunction : hp_scale

  function automatic logic nvm_backed(input logic [7:0] code);
    case (code)
      pmcu_pkg::C_RESTART, pmcu_pkg::C_DISCH, pmcu_pkg::C_ADDR,
      pmcu_pkg::C_PGD, pmcu_pkg::C_NPGD, pmcu_pkg::C_PHASE,
      pmcu_pkg::C_SYNC, pmcu_pkg::C_RAIL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : nvm_backed

  pmcu_state_t      s;
  pmcu_state_t      next_s;
  logic [1:0][15:0] vo;
  logic             hit;
  logic             pg_i;
  logic             killed;
  logic [31:0]      tgt;
  logic             good;

  assign vo = {vout_meas1, vout_meas0};

  always_comb begin
    next_s = s;
    pg_i   = cmd_page;
    killed = (s.kill != 8'h00);
    tgt    = 32'h0;
    good   = 1'b0;
    next_s.r_valid = 1'b0;
    next_s.r_ack   = 1'b0;
    next_s.r_err   = 1'b0;
    next_s.pulse   = 5'h00;
    next_s.run_m   = run_pin;
    next_s.run_s   = s.run_m;
    next_s.win_m   = vout_in_window;
    next_s.win_s   = s.win_m;
    hit = cmd_valid && ((cmd_addr == s.addr) ||
          (!s.rail[0][pmcu_pkg::RAIL_OFF] && cmd_addr == s.rail[0][6:0]) ||
          (!s.rail[1][pmcu_pkg::RAIL_OFF] && cmd_addr == s.rail[1][6:0]));

    // Timestamp advances once per millisecond.
    if (s.ms_cnt == pmcu_pkg::MS_CYC_M1) begin
      next_s.ms_cnt = 15'h0000;
      {next_s.ts_hi, next_s.ts_lo} = {s.ts_hi, s.ts_lo} + 45'h1;
    end else begin
      next_s.ms_cnt = s.ms_cnt + 15'h0001;
    end

    if (meas_valid) begin
      for (int c = 0; c < 2; c++) begin
        if (!s.pk_ok[c] || vo[c] > s.pk_vo[c]) begin
          next_s.pk_vo[c] = vo[c];
          next_s.pk_ok[c] = 1'b1;
        end
      end
      if (!s.pk_ok[2] || l11_fix(vin_meas, pmcu_pkg::L11_SHIFT) >
          l11_fix(s.pk_vi, pmcu_pkg::L11_SHIFT)) begin
        next_s.pk_vi    = vin_meas;
        next_s.pk_ok[2] = 1'b1;
      end
      if (!s.pk_ok[3] || l11_fix(temp_meas, pmcu_pkg::L11_SHIFT) >
          l11_fix(s.pk_t, pmcu_pkg::L11_SHIFT)) begin
        next_s.pk_t     = temp_meas;
        next_s.pk_ok[3] = 1'b1;
      end
    end

    for (int c = 0; c < 2; c++) begin
      case (s.cst[c])
        pmcu_pkg::PMCU_CH_OFF: begin
          if (s.run_s[c] && !killed) begin
            next_s.cst[c] = pmcu_pkg::PMCU_CH_DISCH;
          end
        end
        pmcu_pkg::PMCU_CH_DISCH: begin
          if (!s.run_s[c] || killed) begin
            next_s.cst[c] = pmcu_pkg::PMCU_CH_OFF;
          end else if ({16'h0, vo[c]} <
                       hp_scale(s.disch[c], 32'h1 << pmcu_pkg::UNSIGNED_FIXED_FORMAT_FRAC)) begin
            next_s.cst[c] = pmcu_pkg::PMCU_CH_ON;
          end
        end
        pmcu_pkg::PMCU_CH_ON: begin
          if (!s.run_s[c] || killed) begin
            next_s.cst[c] = pmcu_pkg::PMCU_CH_HOLD;
            next_s.tmr[c] = hp_scale(s.restart[c], pmcu_pkg::MS_CYC);
          end
        end
        pmcu_pkg::PMCU_CH_HOLD: begin
          if (s.tmr[c] <= 32'h1) begin
            next_s.cst[c] = pmcu_pkg::PMCU_CH_OFF;
          end else begin
            next_s.tmr[c] = s.tmr[c] - 32'h1;
          end
        end
        default: next_s.cst[c] = pmcu_pkg::PMCU_CH_OFF;
      endcase
      next_s.en[c] = (next_s.cst[c] == pmcu_pkg::PMCU_CH_ON);

      // Both directions share one counter; any bounce back restarts the wait.
      good = s.win_s[c] && s.en[c];
      tgt  = hp_scale(good ? s.pgd[c] : s.npgd[c], pmcu_pkg::MS_CYC);
      if (good == s.pg[c]) begin
        next_s.pgcnt[c] = 32'h0;
      end else if (s.pgcnt[c] + 32'h1 >= tgt) begin
        next_s.pg[c]    = good;
        next_s.pgcnt[c] = 32'h0;
      end else begin
        next_s.pgcnt[c] = s.pgcnt[c] + 32'h1;
      end
    end

    if (hit) begin
      next_s.r_valid = 1'b1;
      next_s.r_ack   = 1'b1;
      next_s.r_data  = 32'h0;
      next_s.r_aux   = 16'h0;
      case (cmd_kind)
        pmcu_pkg::PMCU_K_WRITE: begin
          if (s.wp != 8'h00 && nvm_backed(cmd_code)) begin
            next_s.r_ack = 1'b0;
            next_s.r_err = 1'b1;
          end else begin
            case (cmd_code)
              pmcu_pkg::C_RESTART: next_s.restart[pg_i] = cmd_wdata[15:0];
              pmcu_pkg::C_VOPK:    next_s.pk_vo[pg_i]   = cmd_wdata[15:0];
              pmcu_pkg::C_VIPK:    next_s.pk_vi         = cmd_wdata[15:0];
              pmcu_pkg::C_TPK:     next_s.pk_t          = cmd_wdata[15:0];
              pmcu_pkg::C_DISCH:   next_s.disch[pg_i]   = cmd_wdata[15:0];
              pmcu_pkg::C_ADDR:    next_s.addr          = cmd_wdata[6:0];
              pmcu_pkg::C_TSHI: begin
                next_s.ts_hi  = cmd_wdata[12:0];
                next_s.ts_lo  = 32'h0;
                next_s.ms_cnt = 15'h0000;
              end
              pmcu_pkg::C_TSLO:    next_s.ts_lo         = cmd_wdata;
              pmcu_pkg::C_PGD:     next_s.pgd[pg_i]     = cmd_wdata[15:0];
              pmcu_pkg::C_NPGD:    next_s.npgd[pg_i]    = cmd_wdata[15:0];
              pmcu_pkg::C_PHASE:   next_s.phase[pg_i]   = cmd_wdata[15:0];
              pmcu_pkg::C_SYNC:    next_s.sync          = cmd_wdata[7:0];
              pmcu_pkg::C_RAIL:    next_s.rail[pg_i]    = cmd_wdata[7:0];
              pmcu_pkg::C_KILL:    next_s.kill = killed ? s.kill : cmd_wdata[7:0];
              pmcu_pkg::C_WP:      next_s.wp            = cmd_wdata[7:0];
              default: begin
                next_s.r_ack = 1'b0;
                next_s.r_err = 1'b1;
              end
            endcase
          end
        end
        pmcu_pkg::PMCU_K_READ: begin
          case (cmd_code)
            pmcu_pkg::C_RESTART: next_s.r_data = {16'h0, s.restart[pg_i]};
            pmcu_pkg::C_VOPK:    next_s.r_data = {16'h0, s.pk_vo[pg_i]};
            pmcu_pkg::C_VIPK:    next_s.r_data = {16'h0, s.pk_vi};
            pmcu_pkg::C_TPK:     next_s.r_data = {16'h0, s.pk_t};
            pmcu_pkg::C_DISCH:   next_s.r_data = {16'h0, s.disch[pg_i]};
            pmcu_pkg::C_PADS:    next_s.r_data = {28'h0, s.run_s, s.win_s};
            pmcu_pkg::C_ADDR:    next_s.r_data = {25'h0, s.addr};
            pmcu_pkg::C_SPID:    next_s.r_data = {16'h0, SPECIAL_ID};
            pmcu_pkg::C_TSHI: begin
              next_s.r_data  = {19'h0, s.ts_hi};
              next_s.ts_snap = s.ts_lo;
            end
            pmcu_pkg::C_TSLO:    next_s.r_data = s.ts_snap;
            pmcu_pkg::C_FLRD: begin
              next_s.r_data = s.fl_lo;
              next_s.r_aux  = {s.fl_ok, 2'h0, s.fl_hi};
            end
            pmcu_pkg::C_COMMON:  next_s.r_data = {28'h0, s.en, s.pg};
            pmcu_pkg::C_CHST:    next_s.r_data = {30'h0, s.cst[pg_i]};
            pmcu_pkg::C_PGD:     next_s.r_data = {16'h0, s.pgd[pg_i]};
            pmcu_pkg::C_NPGD:    next_s.r_data = {16'h0, s.npgd[pg_i]};
            pmcu_pkg::C_PHASE:   next_s.r_data = {16'h0, s.phase[pg_i]};
            pmcu_pkg::C_SYNC:    next_s.r_data = {24'h0, s.sync};
            pmcu_pkg::C_STRAP:   next_s.r_data = 32'h0;
            pmcu_pkg::C_RAIL:    next_s.r_data = {24'h0, s.rail[pg_i]};
            pmcu_pkg::C_KILL:    next_s.r_data = {24'h0, s.kill};
            pmcu_pkg::C_WP:      next_s.r_data = {24'h0, s.wp};
            default: begin
              next_s.r_ack = 1'b0;
              next_s.r_err = 1'b1;
            end
          endcase
        end
        pmcu_pkg::PMCU_K_SEND: begin
          case (cmd_code)
            pmcu_pkg::C_CLRPK: begin
              next_s.pk_ok    = 4'h0;
              next_s.pk_vo    = '0;
              next_s.pk_vi    = 16'h0;
              next_s.pk_t     = 16'h0;
              next_s.pulse[0] = 1'b1;
            end
            pmcu_pkg::C_FLST: begin
              next_s.fl_ok    = 1'b1;
              next_s.fl_hi    = s.ts_hi;
              next_s.fl_lo    = s.ts_lo;
              next_s.pulse[1] = 1'b1;
            end
            pmcu_pkg::C_FLCLR: begin
              next_s.fl_ok    = 1'b0;
              next_s.fl_hi    = 13'h0;
              next_s.fl_lo    = 32'h0;
              next_s.pulse[2] = 1'b1;
            end
            pmcu_pkg::C_NVCMP:   next_s.pulse[3] = 1'b1;
            pmcu_pkg::C_RESET: begin
              next_s = RST;
              next_s.r_valid  = 1'b1;
              next_s.r_ack    = 1'b1;
              next_s.pulse[4] = 1'b1;
            end
            default: begin
              next_s.r_ack = 1'b0;
              next_s.r_err = 1'b1;
            end
          endcase
        end
        default: begin
          next_s.r_ack = 1'b0;
          next_s.r_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= RST;
    end else begin
      s <= next_s;
    end
  end

  assign chan_enable         = s.en;
  assign power_good_output   = s.pg;
  assign sync_pin_is_output  = s.sync[pmcu_pkg::SYNC_DIR];
  assign rsp_valid           = s.r_valid;
  assign rsp_ack             = s.r_ack;
  assign rsp_err             = s.r_err;
  assign rsp_data            = s.r_data;
  assign rsp_aux             = s.r_aux;
  assign peak_clear_command  = s.pulse[0];
  assign fault_record_force  = s.pulse[1];
  assign fault_record_erase  = s.pulse[2];
  assign nvm_compare_command = s.pulse[3];
  assign commanded_restart   = s.pulse[4];
endmodule : pmcu_regs

// ### pmcu_regs_assertions.sv
`timescale 1ns/1ps
module pmcu_regs_assertions (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic [1:0]  vout_in_window,
  input  wire logic [1:0]  chan_enable,
  input  wire logic [1:0]  power_good_output,
  input  wire logic        sync_pin_is_output,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_ack,
  input  wire logic        rsp_err,
  input  wire logic        peak_clear_command,
  input  wire logic        fault_record_force,
  input  wire logic        fault_record_erase,
  input  wire logic        nvm_compare_command,
  input  wire logic        commanded_restart
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic last_kill;
  logic killed;
  // Mirrors the kill latch from the bus traffic alone.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      last_kill <= 1'b0;
      killed    <= 1'b0;
    end else begin
      last_kill <= cmd_valid && cmd_kind == 2'b00 && cmd_code == 8'hFB && cmd_wdata[7:0] != 8'h00;
      if (commanded_restart) killed <= 1'b0;
      else if (rsp_valid && rsp_ack && last_kill) killed <= 1'b1;
    end
  end
  property p_pulse(logic [7:0] c, logic pulse);
    (rsp_valid && rsp_ack && $past(cmd_kind) == 2'b10 && $past(cmd_code) == c) == pulse;
  endproperty
  AST_RSP_AFTER_CMD: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("response without command");
  AST_ACK_OR_ERR: assert property (rsp_valid |-> (rsp_ack ^ rsp_err))
    else $error("not one of ack and err");
  AST_PEAK_CLEAR: assert property (p_pulse(8'hE3, peak_clear_command))
    else $error("peak clear pulse mismatch");
  AST_LOG_FORCE: assert property (p_pulse(8'hEA, fault_record_force))
    else $error("force pulse mismatch");
  AST_LOG_ERASE: assert property (p_pulse(8'hEC, fault_record_erase))
    else $error("erase pulse mismatch");
  AST_NVM_COMPARE: assert property (p_pulse(8'hF0, nvm_compare_command))
    else $error("compare pulse mismatch");
  AST_RESTART: assert property (p_pulse(8'hFD, commanded_restart))
    else $error("restart pulse mismatch");
  AST_PG_RISE: assert property ($rose(power_good_output[0]) |-> $past(chan_enable[0]) &&
    $past(vout_in_window[0], 2) && $past(vout_in_window[0], 3))
    else $error("early power good rise");
  AST_PG_FALL: assert property ($fell(power_good_output[0]) |-> $past(commanded_restart) ||
    !($past(chan_enable[0]) && $past(vout_in_window[0], 2) && $past(vout_in_window[0], 3)))
    else $error("early power good fall");
  AST_HOLD_LOW: assert property ($fell(chan_enable[0]) |=> !chan_enable[0] [*3])
    else $error("early re-enable");
  AST_KILL_OFF: assert property (killed && $past(killed, 4) |-> chan_enable == 2'b00)
    else $error("enabled while killed");
  AST_SYNC_DIR: assert property (rsp_valid && rsp_ack && $past(cmd_kind) == 2'b00 &&
    $past(cmd_code) == 8'hF6 |-> sync_pin_is_output == |($past(cmd_wdata) & 32'h1))
    else $error("sync direction mismatch");
  COV_CLEAR: cover property (peak_clear_command);
  COV_PG: cover property ($rose(power_good_output[0]));
  COV_KILL: cover property ($rose(killed));
endmodule : pmcu_regs_assertions
bind pmcu_regs pmcu_regs_assertions pmcu_regs_assertions_inst (.*);

// ### tb_pmcu_regs.sv
`timescale 1ns/1ps
module tb_pmcu_regs;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cmd_valid, cmd_page;
  logic [1:0]  cmd_kind;
  logic [7:0]  cmd_code;
  logic [6:0]  cmd_addr;
  logic [31:0] cmd_wdata, rsp_data, data;
  logic        meas_valid = 1'b0;
  logic [15:0] vout_meas0 = 16'h0, vout_meas1 = 16'h0, vin_meas = 16'h0, temp_meas = 16'h0;
  logic [1:0]  run_pin = 2'h0, vout_in_window = 2'h0, chan_enable, power_good_output;
  logic        rsp_valid, rsp_ack, rsp_err, sync_pin_is_output, got, err;
  logic [15:0] rsp_aux, aux;
  logic [6:0]  dev_addr = 7'h4F;
  int          fail_count = 0;
  int          total_checks = 0;
  logic [7:0]  dcode [10] = '{8'hDC, 8'hE4, 8'hE6, 8'hF2, 8'hF3, 8'hF5, 8'hF6, 8'hFA, 8'hFB, 8'hFC};
  logic [31:0] dval [10] = '{32'h4900, 32'h3266, 32'h4F, 32'h3C00, 32'h2E66, 32'h59A0,
                             32'h0, 32'h80, 32'h0, 32'h0};
  always #25 ref_clk = ~ref_clk;
  pmcu_regs pmcu_regs_inst (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_page(cmd_page),
    .cmd_wdata(cmd_wdata), .meas_valid(meas_valid), .vout_meas0(vout_meas0),
    .vout_meas1(vout_meas1), .vin_meas(vin_meas), .temp_meas(temp_meas), .run_pin(run_pin),
    .vout_in_window(vout_in_window), .chan_enable(chan_enable),
    .power_good_output(power_good_output), .sync_pin_is_output(sync_pin_is_output),
    .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_err(rsp_err), .rsp_data(rsp_data),
    .rsp_aux(rsp_aux), .peak_clear_command(), .fault_record_force(), .fault_record_erase(),
    .nvm_compare_command(), .commanded_restart());
  pmcu_host_model pmcu_host_model_inst (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_page(cmd_page),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
    .rsp_aux(rsp_aux));
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic op(input logic [1:0] k, input logic [7:0] c, input logic p, input logic [31:0] w);
    pmcu_host_model_inst.xfer(k, c, dev_addr, p, w, got, err, data, aux);
  endtask : op
  task automatic rd(input logic [7:0] c, input logic p);
    op(2'b01, c, p, 32'h0);
  endtask : rd
  task automatic meas(input logic [15:0] a, input logic [15:0] v);
    @(negedge ref_clk);
    vout_meas0 = a;
    vin_meas   = v;
    meas_valid = 1'b1;
    @(negedge ref_clk);
    meas_valid = 1'b0;
  endtask : meas
  task automatic wait_en(input logic want, input int lim);
    for (int i = 0; i < lim && chan_enable[0] !== want; i++) @(negedge ref_clk);
  endtask : wait_en
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(dcode[i], 1'b1);
      check(data, dval[i]);
    end
    rd(8'hE0, 1'b0);
    check(32'(err), 32'h1);
    dev_addr = 7'h11;
    rd(8'hDC, 1'b0);
    check(32'(got), 32'h0);
    dev_addr = 7'h4F;
    op(2'b00, 8'hDC, 1'b1, 32'h1234);
    rd(8'hDC, 1'b0);
    check(data, 32'h4900);
    vout_meas1 = 16'h0300;
    temp_meas = 16'h0019;
    meas(16'h1000, 16'h0005);
    temp_meas = 16'h0010;
    meas(16'h0800, 16'hF808);
    rd(8'hDD, 1'b0);
    check(data, 32'h1000);
    rd(8'hDD, 1'b1);
    check(data, 32'h0300);
    rd(8'hDE, 1'b0);
    check(data, 32'h0005);
    rd(8'hDF, 1'b1);
    check(data, 32'h0019);
    op(2'b10, 8'hE3, 1'b0, 32'h0);
    rd(8'hDF, 1'b0);
    check(data, 32'h0);
    meas(16'h0800, 16'hF808);
    rd(8'hDD, 1'b0);
    check(data, 32'h0800);
    op(2'b00, 8'hE8, 1'b0, 32'h5);
    rd(8'hE8, 1'b0);
    check(data, 32'h5);
    rd(8'hE9, 1'b0);
    check(data, 32'h0);
    op(2'b10, 8'hEA, 1'b0, 32'h0);
    rd(8'hEE, 1'b0);
    check(32'(aux), 32'h8005);
    op(2'b10, 8'hEC, 1'b0, 32'h0);
    op(2'b10, 8'hEC, 1'b0, 32'h0);
    check(32'(err), 32'h0);
    rd(8'hEE, 1'b0);
    check(32'(aux[15]), 32'h0);
    op(2'b10, 8'hF0, 1'b0, 32'h0);
    check(32'(err), 32'h0);
    op(2'b00, 8'hFA, 1'b0, 32'h22);
    dev_addr = 7'h22;
    rd(8'hDC, 1'b0);
    check(data, 32'h4900);
    dev_addr = 7'h4F;
    op(2'b00, 8'hE6, 1'b0, 32'h30);
    rd(8'hE6, 1'b0);
    check(32'(got), 32'h0);
    dev_addr = 7'h30;
    op(2'b00, 8'hF6, 1'b0, 32'h1);
    check(32'(sync_pin_is_output), 32'h1);
    @(negedge ref_clk);
    vout_meas0 = 16'h0100;
    run_pin = 2'b01;
    vout_in_window = 2'b01;
    wait_en(1'b1, 50);
    check(32'(chan_enable[0]), 32'h1);
    repeat (19980) @(negedge ref_clk);
    check(32'(power_good_output[0]), 32'h0);
    repeat (40) @(negedge ref_clk);
    check(32'(power_good_output[0]), 32'h1);
    vout_in_window = 2'b00;
    repeat (1980) @(negedge ref_clk);
    check(32'(power_good_output[0]), 32'h1);
    repeat (40) @(negedge ref_clk);
    check(32'(power_good_output[0]), 32'h0);
    op(2'b00, 8'hFB, 1'b0, 32'h1);
    op(2'b00, 8'hFB, 1'b0, 32'h0);
    rd(8'hFB, 1'b0);
    check(data, 32'h1);
    repeat (100) @(negedge ref_clk);
    check(32'(chan_enable), 32'h0);
    op(2'b10, 8'hFD, 1'b0, 32'h0);
    dev_addr = 7'h4F;
    rd(8'hFB, 1'b0);
    check(data, 32'h0);
    wait_en(1'b1, 50);
    check(32'(chan_enable[0]), 32'h1);
    // A 1 ms hold and a 1 V level fit the run budget.
    op(2'b00, 8'hDC, 1'b0, 32'h3C00);
    op(2'b00, 8'hE4, 1'b0, 32'h3C00);
    meas(16'h2000, 16'h0005);
    run_pin = 2'b00;
    wait_en(1'b0, 20);
    run_pin = 2'b01;
    repeat (19980) @(negedge ref_clk);
    check(32'(chan_enable[0]), 32'h0);
    repeat (100) @(negedge ref_clk);
    check(32'(chan_enable[0]), 32'h0);
    meas(16'h0000, 16'h0005);
    wait_en(1'b1, 20);
    check(32'(chan_enable[0]), 32'h1);
    op(2'b00, 8'hFC, 1'b0, 32'h1);
    op(2'b00, 8'hDC, 1'b0, 32'h0002);
    check(32'(err), 32'h1);
    rd(8'hDC, 1'b0);
    check(data, 32'h3C00);
    finish_test();
  end
endmodule : tb_pmcu_regs
